// ===== logic/cms_pkg.sv
`default_nettype none
package cms_pkg;

  // ============================================================
  // Register map (byte addresses).
  localparam logic [7:0] CMS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMS_STATUS_OFS = 8'h04;
  localparam logic [7:0] CMS_LENGTH_OFS = 8'h08;
  localparam logic [7:0] CMS_COUNT_OFS  = 8'h0C;
  localparam logic [7:0] CMS_DATA_OFS   = 8'h10;

  // ============================================================
  // Control field positions and reset values.
  localparam int CMS_CTRL_RECONF_BIT  = 0;
  localparam int CMS_CTRL_VARIANT_BIT = 1;
  localparam int CMS_CTRL_PULLUP_BIT  = 2;
  localparam logic [2:0]  CMS_CTRL_RST   = 3'h4;
  localparam logic [31:0] CMS_LENGTH_RST = 32'h0000_0100;

  // ============================================================
  // Timing and sizes.
  localparam int          CMS_INIT_DONE_EDGES = 40;
  localparam logic [7:0]  CMS_INIT_CYCLES     = 8'h20;
  localparam int          CMS_BUF_DEPTH       = 2;
  localparam int          CMS_WORD_W          = 32;

  typedef enum logic [1:0] {
    CMS_ST_CONFIG,
    CMS_ST_INIT,
    CMS_ST_USER
  } cms_state_t;

  typedef enum logic [2:0] {
    CMS_SCH_SERIAL,
    CMS_SCH_PAR_SYNC,
    CMS_SCH_PAR_ASYNC,
    CMS_SCH_SER_ASYNC,
    CMS_SCH_RESERVED
  } cms_scheme_t;

  typedef struct packed {
    logic                  valid;
    logic [CMS_WORD_W-1:0] data;
  } cms_word_t;

endpackage
`default_nettype wire

// ===== logic/cms_sequencer.sv
// Behaviour
// R1: Storage is volatile; every power-up needs a full load before user functions.
// R2: After loading, registers and I/O are initialized, then user mode entered.
// R3: Configuration-complete stays low at power-up and loading, rises when loaded.
// R4: Reconfiguration request low drives configuration-complete low.
// R5: User I/O tri-stated during configuration, handed to design after initialization.
// R6: Optional variant enables weak pull-ups on user I/O during configuration.
// R7: Init-complete high while request low and about first 40 clock edges.
// R8: Far side never leaves the load clock floating.
// R9: Far side never leaves the serial load bit floating.
// R10: Active scheme: both sides handshake; data only once both ready.
// R11: Passive schemes: host controls loading and may reconfigure at run time.
// R12: Two-pin decode: 00 serial, 10 parallel synchronous, 11 parallel asynchronous.
// R13: One-pin decode: 0 serial, 1 serial asynchronous.
// R14: Scheme pins change only between configurations.
// R15: Two-pin combination 01 is reserved; no loading starts under it.
// R16: Sequencer has config, init, user states; request low returns to config.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module cms_sequencer
  import cms_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        config_request_n,
  input  wire logic        load_clock_in,
  input  wire logic        serial_load_bit_in,
  input  wire logic        scheme_select_low,
  input  wire logic        scheme_select_high,
  input  wire logic        scheme_select_single,
  input  wire logic        link_ready,
  output logic             device_ready,
  output logic             config_done,
  output logic             init_done,
  output logic             user_io_oe_n,
  output logic             user_io_pullup,
  output logic             user_mode,
  output logic [31:0]      load_word,
  output logic             load_word_valid,
  input  wire logic        load_word_ready
);

  // ============================================================
  // Decoding helpers.
  function automatic cms_scheme_t decode_scheme(input logic single_pin,
                                                input logic hi,
                                                input logic lo,
                                                input logic one);
    if (single_pin) begin
      decode_scheme = one ? CMS_SCH_SER_ASYNC : CMS_SCH_SERIAL; // [R13]
    end else if (!hi && !lo) begin
      decode_scheme = CMS_SCH_SERIAL; // [R12]
    end else if (hi && !lo) begin
      decode_scheme = CMS_SCH_PAR_SYNC; // [R12]
    end else if (hi && lo) begin
      decode_scheme = CMS_SCH_PAR_ASYNC; // [R12]
    end else begin
      decode_scheme = CMS_SCH_RESERVED; // [R15]
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ============================================================
  // State.
  typedef struct packed {
    logic [1:0]  req_s;
    logic [1:0]  clk_s;
    logic [1:0]  bit_s;
    logic [1:0]  lo_s;
    logic [1:0]  hi_s;
    logic [1:0]  one_s;
    logic [1:0]  rdy_s;
    logic        clk_d;
    cms_state_t  st;
    cms_scheme_t scheme;
    logic [2:0]  ctrl;
    logic [31:0] length;
    logic [31:0] count;
    logic [31:0] shift;
    logic [4:0]  nbits;
    logic [5:0]  edges;
    logic [7:0]  init_cnt;
    logic        done;
    logic        started;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
    cms_word_t   sw;
  } cms_state_s_t;

  cms_state_s_t s_r;
  cms_state_s_t s_nxt;
  cms_word_t    buf_in;
  cms_word_t    buf_out;
  logic         buf_in_ready;
  logic         flush;

  cms_word_buf u_buf (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .flush    (flush),
    .in_word  (buf_in),
    .in_ready (buf_in_ready),
    .out_word (buf_out),
    .out_ready(load_word_ready)
  );

  // ============================================================
  // Combined next-state logic.
  logic req_low;
  logic rise;
  logic can_load;

  assign req_low  = ~s_r.req_s[1];
  assign rise     = s_r.clk_s[1] && !s_r.clk_d;
  assign flush    = req_low || s_r.ctrl[CMS_CTRL_RECONF_BIT];
  // Loading waits on the far side's ready, a legal scheme, and buffer room.
  assign can_load = (s_r.st == CMS_ST_CONFIG) && !flush && s_r.rdy_s[1] &&
                    (s_r.scheme != CMS_SCH_RESERVED) && !s_r.done; // [R10] [R15]

  always_comb begin
    s_nxt       = s_r;
    buf_in      = '0;
    s_nxt.req_s = {s_r.req_s[0], config_request_n};
    s_nxt.clk_s = {s_r.clk_s[0], load_clock_in};
    s_nxt.bit_s = {s_r.bit_s[0], serial_load_bit_in};
    s_nxt.lo_s  = {s_r.lo_s[0], scheme_select_low};
    s_nxt.hi_s  = {s_r.hi_s[0], scheme_select_high};
    s_nxt.one_s = {s_r.one_s[0], scheme_select_single};
    s_nxt.rdy_s = {s_r.rdy_s[0], link_ready};
    s_nxt.clk_d = s_r.clk_s[1];
    s_nxt.ctrl[CMS_CTRL_RECONF_BIT] = 1'b0;

    // Scheme pins are sampled only until the first bit of a load is taken, so a mid-load change is ignored.
    if (!s_r.started) begin
      s_nxt.scheme = decode_scheme(s_r.ctrl[CMS_CTRL_VARIANT_BIT], s_r.hi_s[1],
                                   s_r.lo_s[1], s_r.one_s[1]); // [R14]
    end

    case (s_r.st)
      CMS_ST_CONFIG: begin
        if (can_load && rise && buf_in_ready) begin
          s_nxt.started = 1'b1;
          s_nxt.shift   = {s_r.shift[30:0], s_r.bit_s[1]};
          s_nxt.nbits   = s_r.nbits + 5'h01;
          s_nxt.count   = s_r.count + 32'h0000_0001;
          if (s_r.edges != 6'(CMS_INIT_DONE_EDGES)) begin
            s_nxt.edges = s_r.edges + 6'h01; // [R7]
          end
          if (s_r.nbits == 5'h1F) begin
            buf_in.valid = 1'b1;
            buf_in.data  = {s_r.shift[30:0], s_r.bit_s[1]};
          end
          if (s_r.count + 32'h0000_0001 >= s_r.length) begin
            s_nxt.done = 1'b1; // [R1]
          end
        end
        if (s_r.done) begin
          s_nxt.st       = CMS_ST_INIT; // [R2] [R16]
          s_nxt.init_cnt = CMS_INIT_CYCLES;
        end
      end
      CMS_ST_INIT: begin
        if (s_r.init_cnt == 8'h00) begin
          s_nxt.st = CMS_ST_USER; // [R2]
        end else begin
          s_nxt.init_cnt = s_r.init_cnt - 8'h01;
        end
      end
      default: begin
      end
    endcase

    // A reconfiguration request always wins and restarts the whole load.
    if (flush) begin
      s_nxt.st      = CMS_ST_CONFIG; // [R4] [R16]
      s_nxt.done    = 1'b0;
      s_nxt.started = 1'b0;
      s_nxt.count   = '0;
      s_nxt.nbits   = '0;
      s_nxt.edges   = '0;
      s_nxt.shift   = '0;
    end

    // AHB-Lite slave: zero wait states, data phase follows the address phase.
    s_nxt.ap_valid = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      s_nxt.ap_write = hwrite;
      s_nxt.ap_addr  = haddr[7:0];
    end
    if (s_r.ap_valid && s_r.ap_write) begin
      if (hit(s_r.ap_addr, CMS_CTRL_OFS)) begin
        s_nxt.ctrl = hwdata[2:0];
      end else if (hit(s_r.ap_addr, CMS_LENGTH_OFS)) begin
        s_nxt.length = hwdata;
      end
    end
    s_nxt.rdata = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (hit(haddr[7:0], CMS_CTRL_OFS)) begin
        s_nxt.rdata = {29'h0, s_r.ctrl};
      end else if (hit(haddr[7:0], CMS_STATUS_OFS)) begin
        s_nxt.rdata = {25'h0, s_r.scheme, s_r.st, init_done, config_done};
      end else if (hit(haddr[7:0], CMS_LENGTH_OFS)) begin
        s_nxt.rdata = s_r.length;
      end else if (hit(haddr[7:0], CMS_COUNT_OFS)) begin
        s_nxt.rdata = s_r.count;
      end else if (hit(haddr[7:0], CMS_DATA_OFS)) begin
        s_nxt.rdata = buf_out.data;
      end else begin
        s_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r         <= '0;
      s_r.st      <= CMS_ST_CONFIG;
      s_r.scheme  <= CMS_SCH_SERIAL;
      s_r.ctrl    <= CMS_CTRL_RST;
      s_r.length  <= CMS_LENGTH_RST;
      s_r.req_s   <= 2'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // Outputs.
  assign hrdata          = s_r.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  // The far side must stop clocking while the buffer is full or the scheme is illegal,
  // otherwise bits it sends would be dropped and words lost.
  assign device_ready    = (s_r.st == CMS_ST_CONFIG) && !flush && !s_r.done &&
                           (s_r.scheme != CMS_SCH_RESERVED) && buf_in_ready; // [R10] [R15]
  assign config_done     = (s_r.st != CMS_ST_CONFIG); // [R3] [R4]
  assign init_done       = (s_r.st == CMS_ST_USER) ||
                           ((s_r.st == CMS_ST_CONFIG) &&
                            (req_low || (s_r.edges < 6'(CMS_INIT_DONE_EDGES)))); // [R7]
  assign user_io_oe_n    = (s_r.st != CMS_ST_USER); // [R5]
  assign user_io_pullup  = (s_r.st != CMS_ST_USER) && s_r.ctrl[CMS_CTRL_PULLUP_BIT]; // [R6]
  assign user_mode       = (s_r.st == CMS_ST_USER); // [R1]
  assign load_word       = buf_out.data;
  assign load_word_valid = buf_out.valid;

endmodule
`default_nettype wire

// ===== logic/cms_word_buf.sv
`timescale 1ns/10ps
`default_nettype none
module cms_word_buf
  import cms_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      flush,
  input  wire cms_word_t in_word,
  output logic           in_ready,
  output cms_word_t      out_word,
  input  wire logic      out_ready
);

  typedef struct packed {
    logic [CMS_BUF_DEPTH-1:0][CMS_WORD_W-1:0] mem;
    logic                                     wp;
    logic                                     rp;
    logic [1:0]                               cnt;
  } cms_buf_t;

  cms_buf_t s_r;
  cms_buf_t s_nxt;
  logic     push;
  logic     pop;

  assign in_ready       = (s_r.cnt != 2'h2);
  assign out_word       = {(s_r.cnt != 2'h0), s_r.mem[s_r.rp]};
  assign push           = in_word.valid && in_ready;
  assign pop            = out_word.valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_word.data;
      s_nxt.wp          = ~s_r.wp;
    end
    if (pop) begin
      s_nxt.rp = ~s_r.rp;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      s_nxt.wp  = 1'b0;
      s_nxt.rp  = 1'b0;
      s_nxt.cnt = 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== tb/cms_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module cms_link_model (
  input  wire logic enable,
  input  wire logic slow,
  input  wire logic device_ready,
  output logic      load_clock_in,
  output logic      serial_load_bit_in,
  output logic      link_ready
);
  logic [31:0] idx;
  logic [31:0] w;
  // ============
  // Serial memory; the clock rests low between bits.
  initial begin
    load_clock_in = 1'h0;
    serial_load_bit_in = 1'h0;
    link_ready = 1'h0;
    idx = 32'h0;
    #3;
    forever begin
      link_ready = enable;
      if (!enable) idx = 32'h0;
      if (enable && device_ready) begin
        w = 32'hA5C3_0F00 + {5'h0, idx[31:5]};
        serial_load_bit_in = w[5'h1F - idx[4:0]];
        idx = idx + 32'h1;
        #40 load_clock_in = 1'h1;
        #40 load_clock_in = 1'h0;
        if (slow) begin
          // A stale bit would hide a late sample, so it is inverted.
          #20 serial_load_bit_in = ~serial_load_bit_in;
          #140;
        end
      end else begin
        #40 serial_load_bit_in = ~serial_load_bit_in;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cms_seq_properties.sv
`timescale 1ns/10ps
`default_nettype none
module cms_seq_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        config_request_n,
  input wire logic        device_ready,
  input wire logic        config_done,
  input wire logic        init_done,
  input wire logic        user_io_oe_n,
  input wire logic        user_io_pullup,
  input wire logic        user_mode,
  input wire logic [31:0] load_word,
  input wire logic        load_word_valid,
  input wire logic        load_word_ready
);
  // ============
  // Sequences.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Six cycles leave room for the request synchroniser and the state flop.
  sequence req_held;
    !config_request_n [*6];
  endsequence
  sequence load_ended;
    $rose(config_done);
  endsequence
  // ============
  // Properties.
  user_after_load_a: assert property (user_mode |-> config_done)
    else $error("user mode without load");
  init_phase_a: assert property (load_ended |-> !user_mode [*8])
    else $error("user mode skipped init");
  io_tristate_a: assert property (user_io_oe_n != user_mode)
    else $error("user io enable wrong");
  pullup_off_a: assert property (user_mode |-> !user_io_pullup)
    else $error("pull-up in user mode");
  req_drop_a: assert property ($fell(config_request_n) |-> ##[1:6] !config_done)
    else $error("done stayed high");
  req_config_a: assert property (req_held |-> !config_done && !user_mode)
    else $error("request did not return");
  req_init_a: assert property (req_held |-> init_done)
    else $error("init flag low under request");
  ready_config_a: assert property (device_ready |-> !config_done)
    else $error("ready after load");
  stall_hold_a: assert property (load_word_valid && !load_word_ready |=>
    load_word_valid && $stable(load_word))
    else $error("word lost in stall");
endmodule
`default_nettype wire

// ===== tb/test_cms_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_cms_sequencer;
  import cms_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, device_ready, config_done;
  logic        init_done, user_io_oe_n, user_io_pullup, user_mode, load_word_valid;
  logic        config_request_n, load_word_ready, load_clock_in, serial_load_bit_in;
  logic        link_ready, scheme_select_low, scheme_select_high, scheme_select_single;
  logic        mem_on, mem_slow;
  logic [31:0] haddr, hwdata, hrdata, load_word, d;
  logic [1:0]  htrans;
  int          n_errors, checks, rx_n, cyc;
  logic [3:0]  pins [6] = '{4'h0, 4'h8, 4'hC, 4'h1, 4'h3, 4'h4};
  cms_scheme_t sch [6] = '{CMS_SCH_SERIAL, CMS_SCH_PAR_SYNC, CMS_SCH_PAR_ASYNC,
                           CMS_SCH_SERIAL, CMS_SCH_SER_ASYNC, CMS_SCH_RESERVED};

  cms_sequencer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .config_request_n(config_request_n), .load_clock_in(load_clock_in),
    .serial_load_bit_in(serial_load_bit_in), .scheme_select_low(scheme_select_low),
    .scheme_select_high(scheme_select_high), .scheme_select_single(scheme_select_single),
    .link_ready(link_ready), .device_ready(device_ready), .config_done(config_done),
    .init_done(init_done), .user_io_oe_n(user_io_oe_n), .user_io_pullup(user_io_pullup),
    .user_mode(user_mode), .load_word(load_word), .load_word_valid(load_word_valid),
    .load_word_ready(load_word_ready));
  cms_link_model mem (.enable(mem_on), .slow(mem_slow), .device_ready(device_ready),
    .load_clock_in(load_clock_in), .serial_load_bit_in(serial_load_bit_in),
    .link_ready(link_ready));

  always #4 hclk = ~hclk;

  task print_verdict;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    d = hrdata;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task wait_cfg;
    for (int i = 0; i < 4000 && config_done !== 1'h1; i++) @(posedge hclk);
    chk(config_done, 32'h1);
  endtask

  // ============
  // Word sink and hang guard.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_errors++;
      print_verdict;
    end
    if (!mem_on) begin
      rx_n <= 0;
    end else if (load_word_valid === 1'h1 && load_word_ready) begin
      chk(load_word, 32'hA5C3_0F00 + rx_n);
      rx_n <= rx_n + 1;
    end
  end

  // ============
  // Tests.
  initial begin
    {hclk, hresetn, hsel, hwrite, load_word_ready, mem_on, mem_slow} = 7'h0;
    {scheme_select_low, scheme_select_high, scheme_select_single} = 3'h0;
    {haddr, hwdata, htrans} = 66'h0;
    config_request_n = 1'h1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk({user_mode, config_done, init_done, user_io_oe_n, user_io_pullup}, 5'h07);
    rd(CMS_CTRL_OFS, {29'h0, CMS_CTRL_RST});
    rd(CMS_LENGTH_OFS, CMS_LENGTH_RST);
    ahb(1'h1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 6; i++) begin
      {scheme_select_high, scheme_select_low, scheme_select_single} <= pins[i][3:1];
      ahb(1'h1, CMS_CTRL_OFS, {30'h1, pins[i][0], 1'h0});
      repeat (4) @(posedge hclk);
      ahb(1'h0, CMS_STATUS_OFS, 32'h0);
      chk({29'h0, d[6:4]}, {29'h0, sch[i]});
    end
    ahb(1'h1, CMS_LENGTH_OFS, 32'h60);
    mem_on <= 1'h1;
    repeat (100) @(posedge hclk);
    rd(CMS_COUNT_OFS, 32'h0);
    chk({31'h0, device_ready}, 32'h0);
    {scheme_select_high, scheme_select_low} <= 2'h0;
    repeat (1000) @(posedge hclk);
    chk({config_done, init_done, device_ready}, 3'h0);
    load_word_ready <= 1'h1;
    wait_cfg;
    repeat (40) @(posedge hclk);
    chk({user_mode, user_io_oe_n, user_io_pullup, rx_n[1:0]}, 5'h13);
    mem_on <= 1'h0;
    config_request_n <= 1'h0;
    repeat (8) @(posedge hclk);
    chk({config_done, user_mode, init_done, user_io_oe_n}, 4'h3);
    config_request_n <= 1'h1;
    mem_slow <= 1'h1;
    mem_on <= 1'h1;
    wait_cfg;
    repeat (40) @(posedge hclk);
    chk({user_mode, rx_n[1:0]}, 3'h7);
    mem_on <= 1'h0;
    ahb(1'h1, CMS_CTRL_OFS, 32'h5);
    repeat (4) @(posedge hclk);
    chk({config_done, user_mode, user_io_pullup}, 3'h1);
    print_verdict;
  end
endmodule

bind cms_sequencer cms_seq_checker props (.hclk(hclk), .hresetn(hresetn),
  .config_request_n(config_request_n), .device_ready(device_ready),
  .config_done(config_done), .init_done(init_done), .user_io_oe_n(user_io_oe_n),
  .user_io_pullup(user_io_pullup), .user_mode(user_mode), .load_word(load_word),
  .load_word_valid(load_word_valid), .load_word_ready(load_word_ready));
`default_nettype wire
